// ===== flsec_ctrl.sv
// Flash lock and security control: parallel, serial bootloader and service-call paths
`timescale 1ns/1ps
module flsec_ctrl #(
   parameter logic [7:0] HSB_COPY_DEFAULT = 8'h18,
   parameter logic [7:0] MAKER_CODE = 8'h01, // Arbitrary value
   parameter logic [7:0] FAMILY_CODE = 8'h02, // Arbitrary value
   parameter logic [7:0] SIZE_CODE = 8'h03, // Arbitrary value
   parameter logic [7:0] NAME_CODE = 8'h04 // Arbitrary value
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rstn_in,
   // Core side
   input wire logic external_access_pin_in,
   output logic ea_latched_out,
   output logic [15:0] boot_addr_out,
   output logic ext_table_read_block_out,
   output logic ext_exec_block_out,
   output logic [2:0] hw_level_out,
   output logic [1:0] sw_level_out,
   // Parallel programmer
   input wire logic pp_valid_in,
   input wire logic [2:0] pp_cmd_in,
   input wire logic [2:0] pp_index_in,
   input wire logic [7:0] pp_data_in,
   output logic pp_ack_out,
   output logic pp_refused_out,
   output logic [7:0] pp_rdata_out,
   output logic chip_erase_out,
   // Serial bootloader and service calls
   input wire logic sw_valid_in,
   input wire logic sw_from_call_in,
   input wire logic [15:0] sw_entry_pc_in,
   input wire logic [2:0] sw_cmd_in,
   input wire logic [15:0] sw_addr_in,
   input wire logic [7:0] sw_data_in,
   output logic sw_ack_out,
   output logic sw_refused_out,
   output logic [7:0] sw_rdata_out,
   // Flash array port
   input wire logic [7:0] flash_rdata_in,
   output logic [1:0] flash_op_out,
   output logic [15:0] flash_addr_out,
   output logic [7:0] flash_wdata_out
);
   typedef struct packed {
      flsec_pkg::flsec_state_t st;
      logic [7:0] hardware_security_copy;
      logic [7:0] boot_status_byte;
      logic [7:0] software_boot_vector;
      logic [7:0] hsb_copy;
      logic [7:0] software_security_byte;
      logic ea;
      logic [15:0] boot;
      logic tbl_blk;
      logic exe_blk;
      logic [2:0] hlv;
      logic [1:0] slv;
      logic pp_ack;
      logic pp_ref;
      logic [7:0] pp_rd;
      logic erase;
      logic sw_ack;
      logic sw_ref;
      logic [7:0] sw_rd;
      logic [1:0] fop;
      logic [15:0] fadr;
      logic [7:0] fdat;
   } flsec_s_t;

   flsec_s_t s_reg;
   flsec_s_t s_next;

   // Highest programmed lock bit wins; a zero bit is programmed
   function automatic logic [2:0] flsec_hw_level(input logic [2:0] lb);
      if (!lb[2]) flsec_hw_level = flsec_pkg::LVL4;
      else if (!lb[1]) flsec_hw_level = flsec_pkg::LVL3;
      else if (!lb[0]) flsec_hw_level = flsec_pkg::LVL2;
      else flsec_hw_level = flsec_pkg::LVL1;
   endfunction : flsec_hw_level

   function automatic logic [1:0] flsec_sw_level(input logic [7:0] software_security_byte);
      if (!software_security_byte[1]) flsec_sw_level = 2'd3;
      else if (!software_security_byte[0]) flsec_sw_level = 2'd2;
      else flsec_sw_level = 2'd1;
   endfunction : flsec_sw_level

   function automatic logic [7:0] flsec_xaf_rd(input logic [2:0] idx, input flsec_s_t s);
      case (idx)
         flsec_pkg::X_BSB: flsec_xaf_rd = s.boot_status_byte;
         flsec_pkg::X_SBV: flsec_xaf_rd = s.software_boot_vector;
         flsec_pkg::X_HSB: flsec_xaf_rd = s.hsb_copy;
         flsec_pkg::X_SSB: flsec_xaf_rd = s.software_security_byte;
         flsec_pkg::X_MAKER: flsec_xaf_rd = MAKER_CODE;
         flsec_pkg::X_FAMILY: flsec_xaf_rd = FAMILY_CODE;
         flsec_pkg::X_SIZE: flsec_xaf_rd = SIZE_CODE;
         default: flsec_xaf_rd = NAME_CODE;
      endcase
   endfunction : flsec_xaf_rd

   logic [2:0] hlv;
   logic [1:0] slv;
   logic in_system_serial_programming;
   assign hlv = flsec_hw_level(s_reg.hardware_security_copy[2:0]);
   assign slv = flsec_sw_level(s_reg.software_security_byte);
   assign in_system_serial_programming = !sw_from_call_in;

   always_comb begin
      s_next = s_reg;
      s_next.pp_ack = 1'b0;
      s_next.pp_ref = 1'b0;
      s_next.erase = 1'b0;
      s_next.sw_ack = 1'b0;
      s_next.sw_ref = 1'b0;
      s_next.fop = flsec_pkg::FOP_NONE;
      // External access caught on the first edge after reset release
      case (s_reg.st)
         flsec_pkg::ST_CAPTURE: begin
            s_next.ea = external_access_pin_in;
            s_next.st = flsec_pkg::ST_RUN;
         end
         flsec_pkg::ST_RUN: begin
            if (hlv == flsec_pkg::LVL1) begin
               s_next.ea = external_access_pin_in;
            end
         end
         default: s_next.st = flsec_pkg::ST_RUN;
      endcase
      // Parallel port: only hardware lock bits apply here
      if (pp_valid_in) begin
         s_next.pp_ack = 1'b1;
         case (pp_cmd_in)
            flsec_pkg::PP_ERASE: begin
               s_next.erase = 1'b1;
               s_next.hardware_security_copy = flsec_pkg::ERASED;
               s_next.boot_status_byte = flsec_pkg::ERASED;
               s_next.software_boot_vector = flsec_pkg::ERASED;
               s_next.hsb_copy = flsec_pkg::ERASED;
               s_next.software_security_byte = flsec_pkg::ERASED;
               s_next.fop = flsec_pkg::FOP_ERASE;
            end
            flsec_pkg::PP_WR_HSB: begin
               // Bits may only be programmed, so the level can only rise
               s_next.hardware_security_copy = s_reg.hardware_security_copy & pp_data_in;
               s_next.hsb_copy = s_reg.hardware_security_copy & pp_data_in;
            end
            flsec_pkg::PP_RD_HSB: s_next.pp_rd = s_reg.hardware_security_copy;
            flsec_pkg::PP_PROG, flsec_pkg::PP_WR_XAF: begin
               if (hlv >= flsec_pkg::LVL2) begin
                  s_next.pp_ref = 1'b1;
               end else if (pp_cmd_in == flsec_pkg::PP_PROG) begin
                  s_next.fop = flsec_pkg::FOP_WRITE;
                  s_next.fadr = {13'h0000, pp_index_in};
                  s_next.fdat = pp_data_in;
               end else begin
                  case (pp_index_in)
                     flsec_pkg::X_BSB: s_next.boot_status_byte = pp_data_in;
                     flsec_pkg::X_SBV: s_next.software_boot_vector = pp_data_in;
                     flsec_pkg::X_HSB: s_next.hsb_copy = pp_data_in;
                     flsec_pkg::X_SSB: s_next.software_security_byte = s_reg.software_security_byte & pp_data_in;
                     default: s_next.pp_ref = 1'b1;
                  endcase
               end
            end
            flsec_pkg::PP_VERIFY: begin
               if (hlv >= flsec_pkg::LVL3) begin
                  s_next.pp_ref = 1'b1;
                  s_next.pp_rd = flsec_pkg::ERASED;
               end else begin
                  s_next.fop = flsec_pkg::FOP_READ;
                  s_next.pp_rd = flash_rdata_in;
               end
            end
            flsec_pkg::PP_RD_XAF: s_next.pp_rd = flsec_xaf_rd(pp_index_in, s_reg);
            default: s_next.pp_ack = 1'b0;
         endcase
      end else if (sw_valid_in) begin
         // Software path: serial bootloader frames and service calls
         s_next.sw_ack = 1'b1;
         s_next.fadr = sw_addr_in;
         s_next.fdat = sw_data_in;
         if (sw_from_call_in && sw_entry_pc_in != flsec_pkg::SVC_ENTRY) begin
            s_next.sw_ref = 1'b1;
         end else begin
            case (sw_cmd_in)
               flsec_pkg::SW_PROG_BYTE: begin
                  if (in_system_serial_programming && slv >= 2'd2) s_next.sw_ref = 1'b1;
                  else if (!s_reg.hardware_security_copy[flsec_pkg::BLOCK_POS] && sw_addr_in >= flsec_pkg::LOADER_BASE)
                     s_next.sw_ref = 1'b1;
                  else s_next.fop = flsec_pkg::FOP_WRITE;
               end
               flsec_pkg::SW_PROG_SV: begin
                  if (in_system_serial_programming && slv >= 2'd2) s_next.sw_ref = 1'b1;
                  else if (sw_addr_in[0]) s_next.software_boot_vector = sw_data_in;
                  else s_next.boot_status_byte = sw_data_in;
               end
               flsec_pkg::SW_ERASE_SV: begin
                  if (in_system_serial_programming && slv >= 2'd2) s_next.sw_ref = 1'b1;
                  else begin
                     s_next.boot_status_byte = flsec_pkg::ERASED;
                     s_next.software_boot_vector = flsec_pkg::ERASED;
                  end
               end
               flsec_pkg::SW_READ_SV: begin
                  if (in_system_serial_programming && slv == 2'd3) s_next.sw_ref = 1'b1;
                  else s_next.sw_rd = sw_addr_in[0] ? s_reg.software_boot_vector : s_reg.boot_status_byte;
               end
               flsec_pkg::SW_BLANK: begin
                  if (in_system_serial_programming && slv == 2'd3) s_next.sw_ref = 1'b1;
                  else begin
                     s_next.fop = flsec_pkg::FOP_READ;
                     s_next.sw_rd = flash_rdata_in;
                  end
               end
               flsec_pkg::SW_READ_BYTE: begin
                  s_next.fop = flsec_pkg::FOP_READ;
                  s_next.sw_rd = flash_rdata_in;
               end
               flsec_pkg::SW_ERASE_PAGE: begin
                  if (!s_reg.hardware_security_copy[flsec_pkg::BLOCK_POS] && sw_addr_in >= flsec_pkg::LOADER_BASE)
                     s_next.sw_ref = 1'b1;
                  else s_next.fop = flsec_pkg::FOP_ERASE;
               end
               default: s_next.software_security_byte = s_reg.software_security_byte & sw_data_in;
            endcase
         end
      end
      // Decoded protection, registered so outputs come from flops
      s_next.hlv = flsec_hw_level(s_next.hardware_security_copy[2:0]);
      s_next.slv = flsec_sw_level(s_next.software_security_byte);
      s_next.tbl_blk = (s_next.hlv >= flsec_pkg::LVL2);
      s_next.exe_blk = (s_next.hlv == flsec_pkg::LVL4);
      if (!s_next.hardware_security_copy[flsec_pkg::JUMP_POS]) begin
         s_next.boot = flsec_pkg::BOOT_LOADER;
      end else if (s_next.boot_status_byte == flsec_pkg::BSB_APP) begin
         s_next.boot = flsec_pkg::BOOT_APP;
      end else begin
         s_next.boot = {s_next.software_boot_vector, flsec_pkg::VEC_LOW};
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         s_reg <= '0;
         s_reg.st <= flsec_pkg::ST_CAPTURE;
         s_reg.hardware_security_copy <= flsec_pkg::HSB_DELIVERED;
         s_reg.boot_status_byte <= flsec_pkg::BSB_DEFAULT;
         s_reg.software_boot_vector <= flsec_pkg::SBV_DEFAULT;
         s_reg.hsb_copy <= HSB_COPY_DEFAULT;
         s_reg.software_security_byte <= flsec_pkg::SSB_DEFAULT;
         s_reg.hlv <= flsec_pkg::LVL4;
         s_reg.slv <= 2'd1;
         s_reg.tbl_blk <= 1'b1;
         s_reg.exe_blk <= 1'b1;
         s_reg.boot <= flsec_pkg::BOOT_LOADER;
      end else begin
         s_reg <= s_next;
      end
   end

   assign ea_latched_out = s_reg.ea;
   assign boot_addr_out = s_reg.boot;
   assign ext_table_read_block_out = s_reg.tbl_blk;
   assign ext_exec_block_out = s_reg.exe_blk;
   assign hw_level_out = s_reg.hlv;
   assign sw_level_out = s_reg.slv;
   assign pp_ack_out = s_reg.pp_ack;
   assign pp_refused_out = s_reg.pp_ref;
   assign pp_rdata_out = s_reg.pp_rd;
   assign chip_erase_out = s_reg.erase;
   assign sw_ack_out = s_reg.sw_ack;
   assign sw_refused_out = s_reg.sw_ref;
   assign sw_rdata_out = s_reg.sw_rd;
   assign flash_op_out = s_reg.fop;
   assign flash_addr_out = s_reg.fadr;
   assign flash_wdata_out = s_reg.fdat;

   AST_PP_PROG_LOCKED: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      pp_valid_in && pp_cmd_in == flsec_pkg::PP_PROG && hlv >= flsec_pkg::LVL2 |=> pp_refused_out)
      else $error("parallel program not refused");
   AST_PP_VERIFY_LOCKED: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      pp_valid_in && pp_cmd_in == flsec_pkg::PP_VERIFY && hlv >= flsec_pkg::LVL3 |=> pp_refused_out)
      else $error("parallel verify not refused");
   AST_EXEC_BLOCK: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      ext_exec_block_out == (hw_level_out == flsec_pkg::LVL4))
      else $error("execution block disagrees with level");
   AST_NO_LOCK: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      hw_level_out == flsec_pkg::LVL1 |-> !ext_table_read_block_out)
      else $error("table read blocked without lock");
   AST_ERASE_CLEARS: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      pp_valid_in && pp_cmd_in == flsec_pkg::PP_ERASE |=> chip_erase_out ##1 hw_level_out == flsec_pkg::LVL1)
      else $error("chip erase did not clear lock");
   AST_LEVEL_MONO: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      !(pp_valid_in && pp_cmd_in == flsec_pkg::PP_ERASE) |=> hlv >= $past(hlv))
      else $error("lock level dropped without erase");
   AST_SW_L2: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      sw_valid_in && !pp_valid_in && in_system_serial_programming && slv >= 2'd2 && sw_cmd_in == flsec_pkg::SW_PROG_SV |=> sw_refused_out)
      else $error("status program not rejected");
   AST_SW_L3: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      sw_valid_in && !pp_valid_in && in_system_serial_programming && slv == 2'd3 && sw_cmd_in == flsec_pkg::SW_BLANK |=> sw_refused_out)
      else $error("blank check not rejected");
   AST_LOADER_GUARD: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      sw_valid_in && !pp_valid_in && !s_reg.hardware_security_copy[flsec_pkg::BLOCK_POS] && sw_addr_in >= flsec_pkg::LOADER_BASE
      && sw_cmd_in == flsec_pkg::SW_PROG_BYTE |=> flash_op_out != flsec_pkg::FOP_WRITE)
      else $error("loader segment write let through");
   AST_BOOT_LOADER: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      !s_reg.hardware_security_copy[flsec_pkg::JUMP_POS] |-> ##1 boot_addr_out == flsec_pkg::BOOT_LOADER || $past(pp_valid_in))
      else $error("boot address not loader entry");
endmodule : flsec_ctrl

// ===== flsec_pkg.sv
// Constants and types for the Flash lock and security control block
// Functional notes
// - All hardware lock bits unprogrammed: no lock, external table reads see plain code.
// - Level 2 blocks external table reads, latches external access, refuses parallel programming.
// - Level 3 adds refusal of parallel verify reads.
// - Level 4 adds blocking of execution from external program memory.
// - Lock bit one means unprogrammed, zero programmed; don't-care bits ignored.
// - Delivered hardware lock bits encode level four.
// - Lock bits guard the parallel port only; software security bits guard the bootloader.
// - Parallel chip erase clears security byte and erases all Flash and extra array.
// - Delivered security byte has safe, boot-jump, boot-lock bits cleared, level four.
// - Extra array holds security byte copy, defaulting to one of two values.
// - After serial programming, boot status must be zero to boot the application.
// - Software security registers reachable by parallel, serial and service-call commands.
// - Software level 2 rejects program byte, program and erase status/vector.
// - Software level 3 also rejects status/vector reads and blank check.
// - Service calls enter at one fixed address; function chosen by registers.
// - Bootloader turns serial command frames into Flash read, write, erase.
// - Boot-lock bit cleared: software writes to the loader segment are ignored.
// - Boot address with boot-jump set is bottom of memory if boot status is zero, else the boot vector page; loader entry when cleared.
package flsec_pkg;
   localparam logic [7:0] HSB_DELIVERED = 8'h18;
   localparam int SAFE_POS = 7;
   localparam int JUMP_POS = 6;
   localparam int BLOCK_POS = 5;
   localparam logic [7:0] ERASED = 8'hFF;
   localparam logic [7:0] BSB_DEFAULT = 8'hFF;
   localparam logic [7:0] SBV_DEFAULT = 8'hFC;
   localparam logic [7:0] SSB_DEFAULT = 8'hFF;
   localparam logic [7:0] BSB_APP = 8'h00;
   localparam logic [7:0] VEC_LOW = 8'h00;
   localparam logic [15:0] BOOT_APP = 16'h0000;
   localparam logic [15:0] BOOT_LOADER = 16'hFC03;
   localparam logic [15:0] LOADER_BASE = 16'hFC00;
   localparam logic [15:0] SVC_ENTRY = 16'hFFF0;
   // Extra array register indices
   localparam logic [2:0] X_BSB = 3'h0;
   localparam logic [2:0] X_SBV = 3'h1;
   localparam logic [2:0] X_HSB = 3'h2;
   localparam logic [2:0] X_SSB = 3'h3;
   localparam logic [2:0] X_MAKER = 3'h4;
   localparam logic [2:0] X_FAMILY = 3'h5;
   localparam logic [2:0] X_SIZE = 3'h6;
   localparam logic [2:0] X_NAME = 3'h7;
   localparam logic [2:0] LVL1 = 3'h1;
   localparam logic [2:0] LVL2 = 3'h2;
   localparam logic [2:0] LVL3 = 3'h3;
   localparam logic [2:0] LVL4 = 3'h4;
   typedef enum logic [2:0] {
      PP_ERASE = 3'h0, PP_WR_HSB = 3'h1, PP_RD_HSB = 3'h2, PP_PROG = 3'h3,
      PP_VERIFY = 3'h4, PP_WR_XAF = 3'h5, PP_RD_XAF = 3'h6, PP_NOP = 3'h7
   } flsec_pp_cmd_t;
   typedef enum logic [2:0] {
      SW_PROG_BYTE = 3'h0, SW_PROG_SV = 3'h1, SW_ERASE_SV = 3'h2, SW_READ_SV = 3'h3,
      SW_BLANK = 3'h4, SW_READ_BYTE = 3'h5, SW_ERASE_PAGE = 3'h6, SW_WR_SEC = 3'h7
   } flsec_sw_cmd_t;
   typedef enum logic [1:0] {
      FOP_NONE = 2'h0, FOP_READ = 2'h1, FOP_WRITE = 2'h2, FOP_ERASE = 2'h3
   } flsec_fop_t;
   typedef enum logic [1:0] {
      ST_CAPTURE = 2'b01, ST_RUN = 2'b10
   } flsec_state_t;
endpackage : flsec_pkg

// ===== flsec_flash_model.sv
// Behavioural Flash array seen through the block's Flash port
`timescale 1ns/1ps
module flsec_flash_model (
   // Clock
   input wire logic mclk_in,
   // Requests from the block; the read address is the bench's command address
   input wire logic [1:0] flash_op_in,
   input wire logic [15:0] flash_addr_in,
   input wire logic [7:0] flash_wdata_in,
   input wire logic [15:0] rd_addr_in,
   // Read data back, combinational
   output logic [7:0] flash_rdata_out
);
   // Only 256 bytes are kept, so addresses alias; the bench stays in the low page
   logic [7:0] mem_reg [0:255];
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem_reg[i] = 8'hFF;
      end
   end
   always @(posedge mclk_in) begin
      if (flash_op_in == flsec_pkg::FOP_WRITE) begin
         mem_reg[flash_addr_in[7:0]] <= flash_wdata_in;
      end else if (flash_op_in == flsec_pkg::FOP_ERASE) begin
         for (int i = 0; i < 256; i++) begin
            mem_reg[i] <= 8'hFF;
         end
      end
   end
   assign flash_rdata_out = mem_reg[rd_addr_in[7:0]];
endmodule : flsec_flash_model

// ===== flash_lock_security_control_bench.sv
// Self-checking bench for the Flash lock and security control block
`timescale 1ns/1ps
module flash_lock_security_control_bench;
   logic mclk_in = 1'b0, rstn_in = 1'b0, ea = 1'b1, pp_valid = 1'b0, sw_valid = 1'b0, sw_call = 1'b0;
   logic [2:0] pp_cmd = 3'h7, pp_index = 3'h0, sw_cmd = 3'h5;
   logic [7:0] pp_data = 8'h00, sw_data = 8'h00;
   logic [15:0] sw_pc = 16'hFFF0, sw_addr = 16'h0000;
   logic ea_latched, trb, exb, pp_ack, pp_ref, chip_erase, sw_ack, sw_ref;
   logic [15:0] boot_addr, flash_addr;
   logic [2:0] hw_level;
   logic [1:0] sw_level, flash_op;
   logic [7:0] pp_rdata, sw_rdata, flash_wdata, flash_rdata;
   logic erase_s;
   logic [1:0] op_s;
   int fails = 0, n_tests = 0;

   flsec_ctrl u_flsec_ctrl (.mclk_in(mclk_in), .rstn_in(rstn_in), .external_access_pin_in(ea),
      .ea_latched_out(ea_latched), .boot_addr_out(boot_addr), .ext_table_read_block_out(trb),
      .ext_exec_block_out(exb), .hw_level_out(hw_level), .sw_level_out(sw_level), .pp_valid_in(pp_valid),
      .pp_cmd_in(pp_cmd), .pp_index_in(pp_index), .pp_data_in(pp_data), .pp_ack_out(pp_ack),
      .pp_refused_out(pp_ref), .pp_rdata_out(pp_rdata), .chip_erase_out(chip_erase), .sw_valid_in(sw_valid),
      .sw_from_call_in(sw_call), .sw_entry_pc_in(sw_pc), .sw_cmd_in(sw_cmd), .sw_addr_in(sw_addr),
      .sw_data_in(sw_data), .sw_ack_out(sw_ack), .sw_refused_out(sw_ref), .sw_rdata_out(sw_rdata),
      .flash_rdata_in(flash_rdata), .flash_op_out(flash_op), .flash_addr_out(flash_addr),
      .flash_wdata_out(flash_wdata));
   flsec_flash_model u_flsec_flash_model (.mclk_in(mclk_in), .flash_op_in(flash_op), .flash_addr_in(flash_addr),
      .flash_wdata_in(flash_wdata), .rd_addr_in(sw_addr), .flash_rdata_out(flash_rdata));

   initial begin
      forever #2 mclk_in = ~mclk_in;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic close_out;
      $display("checks %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : close_out

   // One parallel command; ack must be up just after the taking edge
   task automatic pp(input logic [2:0] cmd, input logic [2:0] idx, input logic [7:0] d, input logic exp_ref);
      @(posedge mclk_in);
      #1;
      pp_valid = 1'b1;
      pp_cmd = cmd;
      pp_index = idx;
      pp_data = d;
      @(posedge mclk_in);
      #1;
      pp_valid = 1'b0;
      erase_s = chip_erase;
      op_s = flash_op;
      chk(pp_ack, 1'b1);
      chk(pp_ref, exp_ref);
   endtask : pp

   task automatic sw(input logic call, input logic [15:0] pc, input logic [2:0] cmd, input logic [15:0] a,
                     input logic [7:0] d, input logic exp_ref);
      @(posedge mclk_in);
      #1;
      sw_valid = 1'b1;
      sw_call = call;
      sw_pc = pc;
      sw_cmd = cmd;
      sw_addr = a;
      sw_data = d;
      @(posedge mclk_in);
      #1;
      sw_valid = 1'b0;
      op_s = flash_op;
      chk(sw_ack, 1'b1);
      chk(sw_ref, exp_ref);
   endtask : sw

   // Registered status outputs update on the edge that takes a change; two edges are waited
   task automatic lvl(input logic [2:0] hw, input logic t, input logic x);
      repeat (2) @(posedge mclk_in);
      #1;
      chk(hw_level, hw);
      chk(trb, t);
      chk(exb, x);
   endtask : lvl

   task automatic test_reset;
      logic [7:0] dflt [0:3];
      dflt = '{8'hFF, 8'hFC, 8'h18, 8'hFF};
      lvl(3'h4, 1'b1, 1'b1);
      chk(sw_level, 2'h1);
      chk(boot_addr, flsec_pkg::BOOT_LOADER);
      chk(ea_latched, 1'b1);
      pp(flsec_pkg::PP_RD_HSB, 3'h0, 8'h00, 1'b0);
      chk(pp_rdata, 8'h18);
      for (int i = 0; i < 4; i++) begin
         pp(flsec_pkg::PP_RD_XAF, 3'(i), 8'h00, 1'b0);
         chk(pp_rdata, dflt[i]);
      end
   endtask : test_reset

   task automatic test_lvl4_refusals;
      pp(flsec_pkg::PP_PROG, 3'h1, 8'h55, 1'b1);
      pp(flsec_pkg::PP_WR_XAF, flsec_pkg::X_BSB, 8'h00, 1'b1);
      pp(flsec_pkg::PP_VERIFY, 3'h1, 8'h00, 1'b1);
      chk(pp_rdata, 8'hFF);
      sw(1'b1, 16'hFFF0, flsec_pkg::SW_PROG_BYTE, 16'hFC10, 8'h12, 1'b1);
      sw(1'b1, 16'hFFF1, flsec_pkg::SW_READ_BYTE, 16'h0010, 8'h00, 1'b1);
      pp(flsec_pkg::PP_WR_HSB, 3'h0, 8'hFF, 1'b0);
      pp(flsec_pkg::PP_RD_HSB, 3'h0, 8'h00, 1'b0);
      chk(pp_rdata, 8'h18);
      lvl(3'h4, 1'b1, 1'b1);
   endtask : test_lvl4_refusals

   task automatic test_erase;
      pp(flsec_pkg::PP_ERASE, 3'h0, 8'h00, 1'b0);
      chk(erase_s, 1'b1);
      chk(op_s, flsec_pkg::FOP_ERASE);
      lvl(3'h1, 1'b0, 1'b0);
      pp(flsec_pkg::PP_RD_HSB, 3'h0, 8'h00, 1'b0);
      chk(pp_rdata, 8'hFF);
      pp(flsec_pkg::PP_RD_XAF, flsec_pkg::X_SBV, 8'h00, 1'b0);
      chk(pp_rdata, 8'hFF);
      chk(boot_addr, 16'hFF00);
      ea = 1'b0;
      lvl(3'h1, 1'b0, 1'b0);
      chk(ea_latched, 1'b0);
      sw(1'b0, 16'h0000, flsec_pkg::SW_PROG_BYTE, 16'h0010, 8'hA5, 1'b0);
      chk(op_s, flsec_pkg::FOP_WRITE);
      chk(flash_addr, 16'h0010);
      chk(flash_wdata, 8'hA5);
      sw(1'b0, 16'h0000, flsec_pkg::SW_READ_BYTE, 16'h0010, 8'h00, 1'b0);
      chk(sw_rdata, 8'hA5);
      pp(flsec_pkg::PP_WR_XAF, flsec_pkg::X_BSB, flsec_pkg::BSB_APP, 1'b0);
      lvl(3'h1, 1'b0, 1'b0);
      chk(boot_addr, flsec_pkg::BOOT_APP);
   endtask : test_erase

   task automatic test_hw_levels;
      logic [7:0] wr [0:2];
      logic [2:0] lv [0:2];
      logic [2:0] xb, vr;
      wr = '{8'hFE, 8'hFD, 8'hFB};
      lv = '{3'h2, 3'h3, 3'h4};
      xb = 3'b100;
      vr = 3'b110;
      for (int i = 0; i < 3; i++) begin
         pp(flsec_pkg::PP_WR_HSB, 3'h0, wr[i], 1'b0);
         lvl(lv[i], 1'b1, xb[i]);
         pp(flsec_pkg::PP_VERIFY, 3'h2, 8'h00, vr[i]);
         pp(flsec_pkg::PP_PROG, 3'h2, 8'h33, 1'b1);
         sw(1'b1, flsec_pkg::SVC_ENTRY, flsec_pkg::SW_PROG_BYTE, 16'h0020, 8'h44, 1'b0);
      end
   endtask : test_hw_levels

   task automatic test_sw_levels;
      sw(1'b0, 16'h0000, flsec_pkg::SW_WR_SEC, 16'h0000, 8'hFE, 1'b0);
      repeat (2) @(posedge mclk_in);
      #1;
      chk(sw_level, 2'h2);
      sw(1'b0, 16'h0000, flsec_pkg::SW_PROG_BYTE, 16'h0030, 8'h11, 1'b1);
      sw(1'b0, 16'h0000, flsec_pkg::SW_PROG_SV, 16'h0001, 8'h22, 1'b1);
      sw(1'b0, 16'h0000, flsec_pkg::SW_ERASE_SV, 16'h0000, 8'h00, 1'b1);
      sw(1'b0, 16'h0000, flsec_pkg::SW_READ_SV, 16'h0000, 8'h00, 1'b0);
      sw(1'b0, 16'h0000, flsec_pkg::SW_BLANK, 16'h0000, 8'h00, 1'b0);
      sw(1'b1, flsec_pkg::SVC_ENTRY, flsec_pkg::SW_PROG_BYTE, 16'h0030, 8'h11, 1'b0);
      sw(1'b0, 16'h0000, flsec_pkg::SW_WR_SEC, 16'h0000, 8'hFD, 1'b0);
      repeat (2) @(posedge mclk_in);
      #1;
      chk(sw_level, 2'h3);
      sw(1'b0, 16'h0000, flsec_pkg::SW_READ_SV, 16'h0000, 8'h00, 1'b1);
      sw(1'b0, 16'h0000, flsec_pkg::SW_BLANK, 16'h0000, 8'h00, 1'b1);
      sw(1'b0, 16'h0000, flsec_pkg::SW_PROG_SV, 16'h0000, 8'h00, 1'b1);
      pp(flsec_pkg::PP_RD_XAF, flsec_pkg::X_SSB, 8'h00, 1'b0);
      chk(pp_rdata, 8'hFC);
      chk(hw_level, 3'h4);
      pp(flsec_pkg::PP_VERIFY, 3'h2, 8'h00, 1'b1);
   endtask : test_sw_levels

   initial begin
      repeat (10) @(posedge mclk_in);
      #1;
      rstn_in = 1'b1;
      @(posedge mclk_in);
      #1;
      ea = 1'b0;
      test_reset();
      test_lvl4_refusals();
      test_erase();
      test_hw_levels();
      test_sw_levels();
      close_out();
   end

   // About 120 cycles of traffic; over sixteen times that means a hang
   initial begin
      #8000;
      fails++;
      close_out();
   end
endmodule : flash_lock_security_control_bench
